//--- hw/power_seq_defines.svh
// Timing counts and serial setting codes for the module power
// and service sequencer. Assumes a 200 MHz system clock.
// Functional notes
// RL1: Main supply high over 2 ms before enable.
// RL2: Enable high over 2 ms before IO rail.
// RL3: Clear-to-send ready between 100 and 500 ms.
// RL4: IO rail high over 2 ms before ready.
// RL5: IO rail high over 2 ms before inputs.
// RL6: Inputs active before clear-to-send ready.
// RL7: Inputs held low 80 ms after disable.
// RL8: Inputs low before IO rail removed.
// RL9: IO rail removed before main supply drops.
// RL10: Receive data and clear-to-send are active low.
// RL11: Transmit data active low, pulled up idle.
// RL12: Ready-to-send active low, pulled up idle.
// RL13: Service low forces 38400 baud, 8N1.
// RL14: Service never touches stored settings or mode.
// RL15: Service high restores configured serial setting.
// RL16: Service low forces configuration commands on.
// RL17: Host resets with enable low, waits ready.
`ifndef POWER_SEQ_DEFINES_SVH
`define POWER_SEQ_DEFINES_SVH
`define CLK_HZ 200000000
`define GAP_MS 3
`define CTS_MIN_MS 100
`define CTS_MAX_MS 500
`define OFF_HOLD_MS 81
`define CYC_PER_MS (`CLK_HZ / 1000)
`define GAP_CYC (`GAP_MS * `CYC_PER_MS)
`define CTS_MIN_CYC (`CTS_MIN_MS * `CYC_PER_MS)
`define CTS_MAX_CYC (`CTS_MAX_MS * `CYC_PER_MS)
`define OFF_HOLD_CYC (`OFF_HOLD_MS * `CYC_PER_MS)
`define READY_CYC (`CTS_MIN_CYC + `CYC_PER_MS)
`define SERVICE_BAUD 38400
`define SERVICE_BITS 8
`define SERVICE_STOP 1
`endif

//--- hw/power_seq_pkg.sv
// Types shared by both ends of the power and service sequencer.
// Assumes the defines header is compiled alongside.
package power_seq_pkg;
  typedef enum logic [1:0] {par_none, par_even, par_odd} parity_e;
  typedef struct packed {
    logic [17:0] baud;
    logic [3:0] data_bits;
    parity_e parity;
    logic [1:0] stop_bits;
  } serial_cfg_s;
endpackage

//--- hw/power_seq_if.sv
// Pin bundle between host sequencer and module end. Pull-ups on the
// module inputs are resolved here from the host enables.
`timescale 1ns/1ps
`default_nettype none
interface power_seq_if;
  logic main_supply;
  logic module_enable;
  logic io_supply_rail;
  logic gpio_active;
  logic service_n;
  logic receive_data_out_n;
  logic clear_to_send_out_n;
  logic transmit_data_drv_n;
  logic transmit_data_oe;
  logic ready_to_send_drv_n;
  logic ready_to_send_oe;
  logic transmit_data_in_n;
  logic ready_to_send_in_n;
  // Undriven inputs float high through the module pull-ups.
  assign transmit_data_in_n = transmit_data_oe ? transmit_data_drv_n : 1'b1;
  assign ready_to_send_in_n = ready_to_send_oe ? ready_to_send_drv_n : 1'b1;
  modport host (
    output main_supply, module_enable, io_supply_rail, gpio_active,
    output service_n, transmit_data_drv_n, transmit_data_oe,
    output ready_to_send_drv_n, ready_to_send_oe,
    input receive_data_out_n, clear_to_send_out_n
  );
  modport module_end (
    input main_supply, module_enable, io_supply_rail, gpio_active,
    input service_n, transmit_data_in_n, ready_to_send_in_n,
    output receive_data_out_n, clear_to_send_out_n
  );
endinterface
`default_nettype wire

//--- hw/gap_timer.sv
// Counter that reports when a level has been high for a set number of
// cycles. Assumes the level is synchronous to clk_sys.
`timescale 1ns/1ps
`default_nettype none
module gap_timer #(
  parameter int unsigned CYCLES = 600000
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic level,
  output logic done
);
  typedef struct packed {
    logic [31:0] count;
    logic done;
  } gap_s;
  gap_s st_r;
  gap_s st_nxt;
  always_comb
  begin
    st_nxt = st_r;
    if (!level)
    begin
      st_nxt.count = 32'h0;
      st_nxt.done = 1'b0;
    end
    else if (st_r.count >= CYCLES - 1)
    begin
      st_nxt.done = 1'b1;
    end
    else
    begin
      st_nxt.count = st_r.count + 32'h1;
    end
  end
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end
  assign done = st_r.done;
endmodule
`default_nettype wire

//--- hw/module_end.sv
// Module end: clear-to-send timing after enable and the service override of
// the serial setting. Assumes the host keeps its own sequencing order.
`timescale 1ns/1ps
`default_nettype none
`include "power_seq_defines.svh"
module module_end
  import power_seq_pkg::*;
#(
  parameter int unsigned READY_CYC = `READY_CYC,
  parameter int unsigned IO_GAP_CYC = `GAP_CYC
) (
  input wire logic clk_sys,
  input wire logic srst,
  power_seq_if.module_end pins,
  input wire serial_cfg_s configured_cfg,
  input wire logic cfg_cmd_enable,
  input wire logic rx_data,
  output logic [7:0] tx_bits_seen,
  output serial_cfg_s active_cfg,
  output logic cfg_cmd_accept,
  output logic service_active
);
  typedef struct packed {
    logic [31:0] count;
    logic ready;
    logic rd;
    serial_cfg_s cfg;
    logic cmd;
    logic svc;
    logic [7:0] tx;
  } mod_s;
  mod_s st_r;
  mod_s st_nxt;
  logic io_ok;
  gap_timer #(.CYCLES(IO_GAP_CYC)) u_io_gap (
    .clk_sys(clk_sys),
    .srst(srst),
    .level(pins.io_supply_rail),
    .done(io_ok)
  );
  always_comb
  begin
    st_nxt = st_r;
    if (!pins.module_enable)
    begin
      st_nxt.count = 32'h0;
      st_nxt.ready = 1'b0;
    end
    else if (st_r.count < READY_CYC)
    begin
      st_nxt.count = st_r.count + 32'h1;
    end
    else if (io_ok)
    begin
      st_nxt.ready = 1'b1; // [RL3] [RL4]
    end
    st_nxt.svc = !pins.service_n;
    if (!pins.service_n)
    begin
      st_nxt.cfg.baud = 18'(`SERVICE_BAUD); // [RL13]
      st_nxt.cfg.data_bits = 4'(`SERVICE_BITS);
      st_nxt.cfg.parity = par_none;
      st_nxt.cfg.stop_bits = 2'(`SERVICE_STOP);
      st_nxt.cmd = 1'b1; // [RL16]
    end
    else
    begin
      st_nxt.cfg = configured_cfg; // [RL14] [RL15]
      st_nxt.cmd = cfg_cmd_enable;
    end
    // Receive data idles while the host withholds ready-to-send.
    st_nxt.rd = 1'b0;
    if (st_r.ready && !pins.ready_to_send_in_n)
    begin
      st_nxt.rd = rx_data; // [RL12]
    end
    st_nxt.tx = {st_r.tx[6:0], !pins.transmit_data_in_n}; // [RL11]
  end
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end
  assign pins.clear_to_send_out_n = !st_r.ready; // [RL10]
  assign pins.receive_data_out_n = !st_r.rd; // [RL10]
  assign active_cfg = st_r.cfg;
  assign cfg_cmd_accept = st_r.cmd;
  assign service_active = st_r.svc;
  assign tx_bits_seen = st_r.tx;
endmodule
`default_nettype wire

//--- hw/host_seq.sv
// Host end: orders main supply, enable, IO rail and inputs on power-up;
// drops enable and inputs, then IO rail, then main supply on shutdown.
// Assumes power_up is a level from the user.
`timescale 1ns/1ps
`default_nettype none
`include "power_seq_defines.svh"
module host_seq
  import power_seq_pkg::*;
#(
  parameter int unsigned GAP_CYC = `GAP_CYC,
  parameter int unsigned OFF_HOLD_CYC = `OFF_HOLD_CYC
) (
  input wire logic clk_sys,
  input wire logic srst,
  power_seq_if.host pins,
  input wire logic power_up,
  input wire logic service_req,
  input wire logic tx_valid,
  input wire logic tx_bit,
  output logic tx_ready,
  output logic link_ready,
  output logic powered_off
);
  typedef enum logic [2:0] {
    s_off, s_main, s_ena, s_io, s_run, s_hold, s_io_off, s_main_off
  } host_state_e;
  typedef struct packed {
    host_state_e state;
    logic [31:0] count;
    logic main;
    logic ena;
    logic io;
    logic gpio;
    logic svc_n;
    logic txd_n;
    logic oe;
  } host_s;
  host_s st_r;
  host_s st_nxt;
  logic cts;
  assign cts = !pins.clear_to_send_out_n;
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.count = st_r.count + 32'h1;
    st_nxt.svc_n = !service_req; // [RL15]
    st_nxt.txd_n = 1'b1;
    st_nxt.oe = 1'b0;
    case (st_r.state)
      s_off:
      begin
        st_nxt.count = 32'h0;
        if (power_up)
        begin
          st_nxt.main = 1'b1;
          st_nxt.state = s_main;
        end
      end
      s_main:
        if (st_r.count >= GAP_CYC)
        begin
          st_nxt.ena = 1'b1; // [RL1]
          st_nxt.count = 32'h0;
          st_nxt.state = s_ena;
        end
      s_ena:
        if (st_r.count >= GAP_CYC)
        begin
          st_nxt.io = 1'b1; // [RL2]
          st_nxt.count = 32'h0;
          st_nxt.state = s_io;
        end
      s_io:
        if (st_r.count >= GAP_CYC)
        begin
          st_nxt.gpio = 1'b1; // [RL5] [RL6]
          st_nxt.state = s_run;
        end
      s_run:
      begin
        st_nxt.oe = 1'b1;
        st_nxt.txd_n = !(cts && tx_valid && tx_bit); // [RL11] [RL17]
        if (!power_up)
        begin
          st_nxt.ena = 1'b0;
          st_nxt.gpio = 1'b0; // [RL8]
          st_nxt.oe = 1'b0;
          st_nxt.count = 32'h0;
          st_nxt.state = s_hold;
        end
      end
      s_hold:
      begin
        st_nxt.oe = 1'b1;
        st_nxt.txd_n = 1'b0;
        if (st_r.count >= OFF_HOLD_CYC)
        begin
          st_nxt.oe = 1'b0; // [RL7]
          st_nxt.io = 1'b0;
          st_nxt.state = s_io_off;
        end
      end
      s_io_off:
      begin
        st_nxt.main = 1'b0; // [RL9]
        st_nxt.state = s_main_off;
      end
      s_main_off:
        st_nxt.state = s_off;
      default:
        st_nxt.state = s_off;
    endcase
  end
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      st_r <= '0; // [RL17]
      st_r.svc_n <= 1'b1;
      st_r.txd_n <= 1'b1;
    end
    else
      st_r <= st_nxt;
  end
  assign pins.main_supply = st_r.main;
  assign pins.module_enable = st_r.ena;
  assign pins.io_supply_rail = st_r.io;
  assign pins.gpio_active = st_r.gpio;
  assign pins.service_n = st_r.svc_n;
  assign pins.transmit_data_drv_n = st_r.txd_n;
  assign pins.transmit_data_oe = st_r.oe;
  // Ready-to-send is driven low through the off hold like the other inputs.
  assign pins.ready_to_send_drv_n = !(st_r.state == s_run ||
    st_r.state == s_hold); // [RL12] [RL7]
  assign pins.ready_to_send_oe = st_r.oe;
  assign tx_ready = cts && st_r.state == s_run; // [RL17]
  assign link_ready = cts;
  assign powered_off = st_r.state == s_off;
endmodule
`default_nettype wire

//--- verif/power_seq_chk.sv
// Concurrent checks on the pins between host end and module end.
// Assumes every pin is synchronous to clk_sys.
`timescale 1ns/1ps
`default_nettype none
module power_seq_chk #(
  parameter int unsigned READY_CYC = 20
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic main_supply,
  input wire logic module_enable,
  input wire logic io_supply_rail,
  input wire logic gpio_active,
  input wire logic service_n,
  input wire logic clear_to_send_out_n,
  input wire logic transmit_data_drv_n,
  input wire logic transmit_data_oe,
  input wire logic transmit_data_in_n,
  input wire logic ready_to_send_in_n
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  logic [15:0] ena_cyc_r;
  always_ff @(posedge clk_sys)
    ena_cyc_r <= (srst || !module_enable) ? 16'h0 : ena_cyc_r + 16'h1;
  AST_MAIN_ENA: assert property (
    $rose(module_enable) |-> $past(main_supply, 4)) else $error("ena early");
  AST_ENA_IO: assert property (
    $rose(io_supply_rail) |-> $past(module_enable, 4)) else $error("io early");
  AST_CTS_MIN: assert property (
    !clear_to_send_out_n |-> ena_cyc_r >= READY_CYC) else $error("cts early");
  AST_CTS_MAX: assert property (
    module_enable && ena_cyc_r == 5 * READY_CYC |-> !clear_to_send_out_n)
    else $error("cts late");
  AST_IO_CTS: assert property (
    $fell(clear_to_send_out_n) |-> $past(io_supply_rail, 4))
    else $error("cts before io gap");
  AST_IO_GPIO: assert property (
    $rose(gpio_active) |-> $past(io_supply_rail, 4)) else $error("gpio early");
  AST_GPIO_CTS: assert property (
    $fell(clear_to_send_out_n) |-> gpio_active) else $error("gpio late");
  AST_OFF_HOLD: assert property (
    $fell(module_enable) |=> (transmit_data_oe && !transmit_data_drv_n)[*8])
    else $error("input not held low");
  AST_RTS_HOLD: assert property (
    $fell(module_enable) |=> (!ready_to_send_in_n)[*8])
    else $error("ready-to-send not held low");
  AST_GPIO_IO_OFF: assert property (
    $fell(io_supply_rail) |-> !gpio_active) else $error("gpio still on");
  AST_IO_MAIN_OFF: assert property (
    $fell(main_supply) |-> !io_supply_rail && !module_enable)
    else $error("main dropped first");
  AST_CTS_DROP: assert property (
    $fell(module_enable) |=> clear_to_send_out_n) else $error("cts stuck");
  AST_PULL_UP: assert property (
    !transmit_data_oe |-> transmit_data_in_n) else $error("no pull-up");
  COV_READY: cover property ($fell(clear_to_send_out_n));
  COV_SERVICE: cover property ($fell(service_n));
  COV_OFF: cover property ($fell(main_supply));
endmodule
`default_nettype wire

//--- verif/module_power_service_sequencer_test.sv
// Self-checking bench: host end and module end joined by the pin bundle.
// Assumes shortened timing parameters so the run stays brief.
`timescale 1ns/1ps
`default_nettype none
module module_power_service_sequencer_test
  import power_seq_pkg::*;
;
  localparam int unsigned RDY = 20;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic power_up = 1'b0;
  logic service_req = 1'b0;
  logic tx_valid = 1'b0;
  logic tx_bit = 1'b0;
  logic cfg_cmd_enable = 1'b0;
  logic rx_data = 1'b0;
  serial_cfg_s configured_cfg = '{18'h2580, 4'h7, par_even, 2'h2};
  localparam serial_cfg_s svc_cfg_exp = '{18'h9600, 4'h8, par_none, 2'h1};
  serial_cfg_s active_cfg;
  logic tx_ready, link_ready, powered_off, cfg_cmd_accept, service_active;
  logic [7:0] tx_bits_seen;
  int failures = 0;
  int checked = 0;
  int n;
  power_seq_if pins ();
  always #2.5 clk_sys = ~clk_sys;
  host_seq #(.GAP_CYC(4), .OFF_HOLD_CYC(8)) u_host_seq (.clk_sys(clk_sys),
    .srst(srst), .pins(pins), .power_up(power_up), .service_req(service_req),
    .tx_valid(tx_valid), .tx_bit(tx_bit), .tx_ready(tx_ready),
    .link_ready(link_ready), .powered_off(powered_off));
  module_end #(.READY_CYC(RDY), .IO_GAP_CYC(4)) u_module_end (
    .clk_sys(clk_sys), .srst(srst), .pins(pins),
    .configured_cfg(configured_cfg), .cfg_cmd_enable(cfg_cmd_enable),
    .rx_data(rx_data), .tx_bits_seen(tx_bits_seen), .active_cfg(active_cfg),
    .cfg_cmd_accept(cfg_cmd_accept), .service_active(service_active));
  power_seq_chk #(.READY_CYC(RDY)) u_power_seq_chk (.clk_sys(clk_sys),
    .srst(srst), .main_supply(pins.main_supply),
    .module_enable(pins.module_enable), .io_supply_rail(pins.io_supply_rail),
    .gpio_active(pins.gpio_active), .service_n(pins.service_n),
    .clear_to_send_out_n(pins.clear_to_send_out_n),
    .transmit_data_drv_n(pins.transmit_data_drv_n),
    .transmit_data_oe(pins.transmit_data_oe),
    .transmit_data_in_n(pins.transmit_data_in_n),
    .ready_to_send_in_n(pins.ready_to_send_in_n));
  task automatic print_verdict();
    $display("counts: checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] ex,
    input logic [31:0] got);
    checked++;
    if (got !== ex)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, ex, got);
    end
  endtask
  // Picks the pin that a wait watches: 0 enable, 1 clear-to-send, 2 main.
  function automatic logic pick(input int sel);
    case (sel)
      0: return pins.module_enable;
      1: return pins.clear_to_send_out_n;
      default: return pins.main_supply;
    endcase
  endfunction
  // Waits are sampled on the falling edge, where all outputs have settled.
  task automatic wait_sig(input int sel, input logic v, output int k);
    k = 0;
    while (pick(sel) !== v && k < 1000)
    begin
      @(negedge clk_sys);
      k++;
    end
    if (pick(sel) !== v)
    begin
      failures++;
      print_verdict();
    end
  endtask
  initial
  begin
    repeat (3) @(posedge clk_sys);
    srst <= 1'b0;
    tx_valid <= 1'b1;
    tx_bit <= 1'b1;
    power_up <= 1'b1;
    repeat (3) @(negedge clk_sys);
    chk("cts_n_idle", 1, pins.clear_to_send_out_n);
    chk("tx_ready_early", 0, tx_ready);
    wait_sig(0, 1'b1, n);
    wait_sig(1, 1'b0, n);
    chk("cts_delay_ok", 1, n >= RDY && n <= 5 * RDY);
    chk("gpio_on", 1, pins.gpio_active);
    chk("link_ready", 1, link_ready);
    chk("tx_ready", 1, tx_ready);
    repeat (10) @(negedge clk_sys);
    chk("tx_ones", 8'hff, tx_bits_seen);
    @(posedge clk_sys);
    tx_bit <= 1'b0;
    rx_data <= 1'b1;
    repeat (12) @(negedge clk_sys);
    chk("tx_zeros", 8'h00, tx_bits_seen);
    chk("rd_n_low", 0, pins.receive_data_out_n);
    @(posedge clk_sys);
    tx_valid <= 1'b0;
    rx_data <= 1'b0;
    service_req <= 1'b1;
    repeat (4) @(negedge clk_sys);
    chk("rd_n_high", 1, pins.receive_data_out_n);
    $display("test power_up done");
    chk("svc_cfg", svc_cfg_exp, active_cfg);
    chk("svc_on", 1, service_active);
    chk("cmd_forced", 1, cfg_cmd_accept);
    chk("cts_kept", 0, pins.clear_to_send_out_n);
    @(posedge clk_sys);
    service_req <= 1'b0;
    repeat (4) @(negedge clk_sys);
    chk("cfg_back", configured_cfg, active_cfg);
    chk("cmd_off", 0, cfg_cmd_accept);
    chk("svc_off", 0, service_active);
    @(posedge clk_sys);
    cfg_cmd_enable <= 1'b1;
    repeat (3) @(negedge clk_sys);
    chk("cmd_on", 1, cfg_cmd_accept);
    $display("test service done");
    // Stay up long enough for the late clear-to-send bound to be checked.
    repeat (60) @(posedge clk_sys);
    power_up <= 1'b0;
    wait_sig(0, 1'b0, n);
    repeat (2) @(negedge clk_sys);
    chk("cts_n_off", 1, pins.clear_to_send_out_n);
    chk("td_held_low", 0, pins.transmit_data_in_n);
    chk("rts_held_low", 0, pins.ready_to_send_in_n);
    wait_sig(2, 1'b0, n);
    chk("io_off", 0, pins.io_supply_rail);
    chk("gpio_off", 0, pins.gpio_active);
    @(negedge clk_sys);
    chk("powered_off", 1, powered_off);
    $display("test shutdown done");
    print_verdict();
  end
endmodule
`default_nettype wire
